//--- rx_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module rx_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] count;
  } fifo_s;

  fifo_s s_q;
  fifo_s s_d;
  logic push;
  logic pop;

  assign in_ready = (s_q.count != FULL_COUNT);
  assign out_valid = (s_q.count != '0);
  assign out_data = s_q.mem[s_q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = s_q.wp + AW'(1);
    end
    if (pop) begin
      s_d.rp = s_q.rp + AW'(1);
    end
    if (push && !pop) begin
      s_d.count = s_q.count + CW'(1);
    end else if (pop && !push) begin
      s_d.count = s_q.count - CW'(1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

//--- uart_err_baud.sv
// Behaviour
// (RULE1) parity mismatch sets parity error flag
// (RULE2) missing stop bit sets framing error flag
// (RULE3) unread buffer at completion sets overrun
// (RULE4) receiver checks only one stop bit
// (RULE5) overrun repeats every frame until buffer read
// (RULE6) error status read-only, upper bits zero
// (RULE7) baud control resets zero, select in 7:4
// (RULE8) codes 0-7 divide clock by 2^(code+1)
// (RULE9) code 8 selects external baud pin
// (RULE10) internal bit rate is divided clock over 8
// (RULE11) bit clock only from system or pin
// (RULE12) software never writes control mid-transfer
// (RULE13) no n=1 above 2.5 MHz clock
// (RULE14) stop transfers before changing mode
// (RULE15) port direction makes clock pin input
// (RULE16) buffer read or next frame clears flags
// (RULE17) external bit rate is pin clock over 16
// (RULE18) errored character still loaded, irq raised
// (RULE19) flags update with buffer load cycle
`timescale 1ns/10ps
`default_nettype none
module uart_err_baud
  import uart_err_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic rx_enable,
  input wire logic [1:0] parity_mode,
  input wire logic char_len_8,
  input wire logic rxd,
  input wire logic ext_baud_clock_pin,
  output logic baud_bit_tick,
  output logic rx_complete_irq,
  output logic [FIFO_WIDTH-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready
);
  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP
  } rx_state_e;

  typedef struct packed {
    logic [3:0] baud_sel;
    logic parity_err_flag;
    logic framing_err_flag;
    logic overrun_err_flag;
    logic [7:0] rx_buffer;
    logic buf_full;
    logic [7:0] rdata;
    logic [7:0] prescale;
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
    logic ext_half;
    logic rxd_meta;
    logic rxd_sync;
    logic [2:0] bit_div;
    logic bit_tick;
    rx_state_e state;
    logic [2:0] cnt;
    logic [2:0] bit_idx;
    logic [7:0] shift;
    logic par_bit;
    logic irq;
    logic push;
    logic [FIFO_WIDTH-1:0] push_data;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic fifo_in_ready;
  logic sample_tick;
  logic [7:0] div_mask;
  logic ones_odd;
  logic par_err;
  logic read_status;
  logic read_buffer;

  rx_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_data(s_q.push_data),
    .in_valid(s_q.push),
    .in_ready(fifo_in_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  // mask of n low bits, n = code + 1
  assign div_mask = 8'((9'h002 << s_q.baud_sel) - 9'h001); // see (RULE8)

  always_comb begin
    sample_tick = 1'b0;
    if (s_q.baud_sel <= SEL_MAX_INTERNAL) begin
      sample_tick = ((s_q.prescale & div_mask) == div_mask); // see (RULE8) see (RULE11)
    end else if (s_q.baud_sel == SEL_EXTERNAL) begin
      // two pin edges per sample, eight samples per bit: pin over 16
      sample_tick = s_q.ext_sync && !s_q.ext_prev && s_q.ext_half; // see (RULE9) see (RULE17)
    end
  end

  assign ones_odd = ^s_q.shift ^ s_q.par_bit;
  assign par_err = ((parity_mode == PAR_ODD) && !ones_odd) ||
                   ((parity_mode == PAR_EVEN) && ones_odd); // see (RULE1)
  assign read_status = reg_rd && (reg_addr == ERR_STATUS_ADDR);
  assign read_buffer = reg_rd && (reg_addr == RX_BUFFER_ADDR);

  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.push = 1'b0;
    s_d.bit_tick = 1'b0;
    // pin synchronisers; first stage feeds only the second
    s_d.ext_meta = ext_baud_clock_pin;
    s_d.ext_sync = s_q.ext_meta;
    s_d.ext_prev = s_q.ext_sync;
    s_d.rxd_meta = rxd;
    s_d.rxd_sync = s_q.rxd_meta;
    s_d.prescale = s_q.prescale + 8'h01;
    if (s_q.ext_sync && !s_q.ext_prev) begin
      s_d.ext_half = !s_q.ext_half;
    end
    if (sample_tick) begin
      s_d.bit_div = s_q.bit_div + 3'h1;
      s_d.bit_tick = (s_q.bit_div == FULL_BIT_TICKS); // see (RULE10)
    end

    // register reads return the value one cycle later
    if (reg_rd) begin
      s_d.rdata = 8'h00;
      if (read_status) begin
        s_d.rdata[PE_BIT] = s_q.parity_err_flag; // see (RULE6)
        s_d.rdata[FE_BIT] = s_q.framing_err_flag;
        s_d.rdata[OVE_BIT] = s_q.overrun_err_flag;
      end else if (reg_addr == BAUD_CTRL_ADDR) begin
        s_d.rdata[7:BAUD_SEL_LSB] = s_q.baud_sel; // see (RULE7)
      end else if (read_buffer) begin
        s_d.rdata = s_q.rx_buffer;
      end
    end
    // only the select nibble is kept; status is not writable
    if (reg_wr && (reg_addr == BAUD_CTRL_ADDR)) begin
      s_d.baud_sel = reg_wdata[7:BAUD_SEL_LSB]; // see (RULE7)
    end
    if (read_buffer) begin
      s_d.buf_full = 1'b0;
      s_d.parity_err_flag = 1'b0; // see (RULE16)
      s_d.framing_err_flag = 1'b0;
      s_d.overrun_err_flag = 1'b0;
    end

    if (sample_tick) begin
      s_d.cnt = s_q.cnt + 3'h1;
    end
    unique case (s_q.state)
      RX_IDLE: begin
        // waits for fifo room; a frame that starts while the fifo is full is not received
        if (sample_tick && !s_q.rxd_sync && fifo_in_ready) begin
          s_d.state = RX_START;
          s_d.cnt = 3'h0;
        end
      end
      RX_START: begin
        if (sample_tick && (s_q.cnt == HALF_BIT_TICKS)) begin
          s_d.cnt = 3'h0;
          s_d.bit_idx = 3'h0;
          s_d.shift = 8'h00;
          s_d.state = s_q.rxd_sync ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (sample_tick && (s_q.cnt == FULL_BIT_TICKS)) begin
          s_d.shift[s_q.bit_idx] = s_q.rxd_sync;
          s_d.bit_idx = s_q.bit_idx + 3'h1;
          if (s_q.bit_idx == (char_len_8 ? LAST_BIT_8 : LAST_BIT_7)) begin
            s_d.state = (parity_mode == PAR_NONE) ? RX_STOP : RX_PARITY;
          end
        end
      end
      RX_PARITY: begin
        if (sample_tick && (s_q.cnt == FULL_BIT_TICKS)) begin
          s_d.par_bit = (parity_mode == PAR_NONE) ? 1'b0 : s_q.rxd_sync;
          s_d.state = RX_STOP;
        end
      end
      RX_STOP: begin
        // a second stop bit is never checked
        if (sample_tick && (s_q.cnt == FULL_BIT_TICKS)) begin // see (RULE4)
          s_d.state = RX_IDLE;
          s_d.rx_buffer = s_q.shift; // see (RULE18)
          s_d.buf_full = 1'b1;
          // new frame replaces all flags; wins over a same-cycle read
          s_d.parity_err_flag = par_err; // see (RULE1) see (RULE16) see (RULE19)
          s_d.framing_err_flag = !s_q.rxd_sync; // see (RULE2) see (RULE19)
          s_d.overrun_err_flag = s_q.buf_full && !read_buffer; // see (RULE3) see (RULE5)
          s_d.irq = 1'b1; // see (RULE18)
          s_d.push = 1'b1;
          s_d.push_data = {par_err, !s_q.rxd_sync, s_q.buf_full && !read_buffer, s_q.shift};
        end
      end
    endcase
    // odd/even parity pre-clear so zero-parity frames never flag
    if (s_q.state != RX_PARITY && s_q.state != RX_STOP) begin
      s_d.par_bit = 1'b0;
    end
    // disabling reception aborts at once; a frame completing in that same cycle still loads buffer and flags
    if (!rx_enable) begin
      s_d.state = RX_IDLE;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.baud_sel <= BAUD_SEL_RESET; // see (RULE7)
      s_q.rx_buffer <= RX_BUFFER_RESET;
      s_q.parity_err_flag <= ERR_STATUS_RESET[PE_BIT]; // see (RULE6)
      s_q.framing_err_flag <= ERR_STATUS_RESET[FE_BIT];
      s_q.overrun_err_flag <= ERR_STATUS_RESET[OVE_BIT];
      s_q.state <= RX_IDLE;
      // line idles high; a low reset value would look like a start bit
      s_q.rxd_meta <= 1'b1;
      s_q.rxd_sync <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign baud_bit_tick = s_q.bit_tick;
  assign rx_complete_irq = s_q.irq;
endmodule
`default_nettype wire

//--- uart_err_baud_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module uart_err_baud_monitor
  import uart_err_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_enable,
  input wire logic [1:0] parity_mode,
  input wire logic char_len_8,
  input wire logic rxd,
  input wire logic ext_baud_clock_pin,
  input wire logic baud_bit_tick,
  input wire logic rx_complete_irq,
  input wire logic [FIFO_WIDTH-1:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_done;
    rx_complete_irq ##1 rx_valid;
  endsequence
  a_tick_one_cycle: assert property (baud_bit_tick |=> !baud_bit_tick)
    else $error("bit tick too long");
  a_irq_one_cycle: assert property (rx_complete_irq |=> !rx_complete_irq)
    else $error("irq too long");
  a_irq_loads_fifo: assert property (rx_complete_irq |-> s_done)
    else $error("frame not queued");
  a_status_upper_zero: assert property (s_rd(ERR_STATUS_ADDR) |=> reg_rdata[7:3] == 5'h00)
    else $error("status upper bits set");
  a_baud_low_zero: assert property (s_rd(BAUD_CTRL_ADDR) |=> reg_rdata[3:0] == 4'h0)
    else $error("baud low bits set");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_read_clears_flags: assert property (s_rd(RX_BUFFER_ADDR) ##1 (reg_rd
    && reg_addr == ERR_STATUS_ADDR && !rx_complete_irq) |=> reg_rdata[2:0] == 3'h0)
    else $error("flags not cleared");
  a_fifo_head_holds: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("fifo head lost");
endmodule
bind uart_err_baud uart_err_baud_monitor uart_err_baud_monitor_inst (
  .clock(clock),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .rx_enable(rx_enable),
  .parity_mode(parity_mode),
  .char_len_8(char_len_8),
  .rxd(rxd),
  .ext_baud_clock_pin(ext_baud_clock_pin),
  .baud_bit_tick(baud_bit_tick),
  .rx_complete_irq(rx_complete_irq),
  .rx_data(rx_data),
  .rx_valid(rx_valid),
  .rx_ready(rx_ready)
);
`default_nettype wire

//--- uart_err_baud_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module uart_err_baud_tb_top
  import uart_err_pkg::*;
;
  logic clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rx_enable = 1'b1;
  logic char_len_8 = 1'b1, ext_baud_clock_pin = 1'b0, rx_ready = 1'b0, ext_on = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [1:0] parity_mode = 2'h3;
  logic rxd, baud_bit_tick, rx_complete_irq, rx_valid;
  logic [FIFO_WIDTH-1:0] rx_data;
  int n_fail = 0, comparisons = 0, n_irq = 0;
  uart_err_baud uart_err_baud_inst (
    .clock(clock),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .rx_enable(rx_enable),
    .parity_mode(parity_mode),
    .char_len_8(char_len_8),
    .rxd(rxd),
    .ext_baud_clock_pin(ext_baud_clock_pin),
    .baud_bit_tick(baud_bit_tick),
    .rx_complete_irq(rx_complete_irq),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .rx_ready(rx_ready)
  );
  // code 1 gives 32 clocks per bit; code 0 is out of range at this clock
  uart_line_partner #(.BIT_CLKS(32)) uart_line_partner_inst (.clock(clock), .rxd(rxd));
  always #2 clock = ~clock;
  always #16 if (ext_on) ext_baud_clock_pin = ~ext_baud_clock_pin;
  always @(negedge clock) if (rx_complete_irq === 1'b1) n_irq++;
  task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask
  // buffer read then status read on the very next edge
  task automatic rd2(output logic [7:0] d0, output logic [7:0] d1);
    @(negedge clock);
    reg_addr = RX_BUFFER_ADDR;
    reg_rd = 1'b1;
    @(negedge clock);
    d0 = reg_rdata;
    reg_addr = ERR_STATUS_ADDR;
    @(negedge clock);
    d1 = reg_rdata;
    reg_rd = 1'b0;
  endtask
  task automatic pop;
    @(negedge clock);
    rx_ready = 1'b1;
    @(negedge clock);
    rx_ready = 1'b0;
  endtask
  task automatic frame(input logic [7:0] b, input int nb, input logic hp, p, st,
    input logic [10:0] e);
    logic [7:0] r;
    int k;
    int q;
    q = n_irq;
    uart_line_partner_inst.send(b, nb, hp, p, st);
    k = 0;
    while (rx_valid !== 1'b1 && k < 400) begin
      @(negedge clock);
      k++;
    end
    `CHK(rx_data, e)
    `CHK(n_irq, q + 1)
    rd(ERR_STATUS_ADDR, r);
    `CHK(r, {5'h00, e[10:8]})
    pop;
  endtask
  task automatic t_reset;
    logic [7:0] r;
    rd(ERR_STATUS_ADDR, r);
    `CHK(r, ERR_STATUS_RESET)
    rd(BAUD_CTRL_ADDR, r);
    `CHK(r, 8'h00)
    wr(ERR_STATUS_ADDR, 8'hFF);
    rd(ERR_STATUS_ADDR, r);
    `CHK(r, 8'h00)
    rd(16'hFF75, r);
    `CHK(r, 8'h00)
  endtask
  task automatic t_errors;
    logic [7:0] r;
    logic [7:0] r2;
    frame(8'hA5, 8, 1'b1, 1'b0, 1'b1, 11'h0A5);
    rd(RX_BUFFER_ADDR, r);
    frame(8'h3C, 8, 1'b1, 1'b1, 1'b0, {3'h6, 8'h3C});
    frame(8'h11, 8, 1'b1, 1'b0, 1'b1, {3'h1, 8'h11});
    frame(8'h22, 8, 1'b1, 1'b0, 1'b1, {3'h1, 8'h22});
    rd2(r, r2);
    `CHK(r, 8'h22)
    `CHK(r2, 8'h00)
  endtask
  // receiver switched off mid-frame: nothing reported, nothing queued
  task automatic t_abort;
    logic [7:0] r;
    int q;
    q = n_irq;
    fork
      uart_line_partner_inst.send(8'h5A, 8, 1'b1, 1'b0, 1'b1);
    join_none
    repeat (40) @(negedge clock);
    rx_enable = 1'b0;
    wait fork;
    @(negedge clock);
    rx_enable = 1'b1;
    repeat (4) @(negedge clock);
    `CHK(n_irq, q)
    `CHK(rx_valid, 1'b0)
    rd(ERR_STATUS_ADDR, r);
    `CHK(r, 8'h00)
  endtask
  task automatic t_modes;
    logic [7:0] r;
    for (int m = 0; m < 4; m++) begin
      rx_enable = 1'b0;
      @(negedge clock);
      parity_mode = 2'(m);
      char_len_8 = m[0];
      rx_enable = 1'b1;
      frame(8'h81, m[0] ? 8 : 7, m != 0, 1'b1, 1'b1, {m >= 2, 2'b00, m[0] ? 8'h81 : 8'h01});
      rd(RX_BUFFER_ADDR, r);
    end
  endtask
  task automatic t_fifo;
    logic [7:0] r;
    for (int i = 0; i < 17; i++) begin
      uart_line_partner_inst.send(8'(i), 8, 1'b1, ^8'(i), 1'b1);
      rd(RX_BUFFER_ADDR, r);
    end
    for (int i = 0; i < 16; i++) begin
      `CHK(rx_data, 11'(i))
      pop;
    end
    `CHK(rx_valid, 1'b0)
  endtask
  task automatic gap(output int n);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (baud_bit_tick !== 1'b1 && n < 5000);
  endtask
  task automatic t_baud;
    logic [7:0] r;
    int n;
    for (int c = 1; c < 9; c++) begin
      ext_on = (c == 8);
      wr(BAUD_CTRL_ADDR, 8'(c << 4));
      rd(BAUD_CTRL_ADDR, r);
      `CHK(r, 8'(c << 4))
      gap(n);
      gap(n);
      gap(n);
      `CHK(n, c == 8 ? 128 : 8 << (c + 1))
    end
  endtask
  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_reset;
    wr(BAUD_CTRL_ADDR, 8'h10);
    t_errors;
    t_modes;
    t_abort;
    t_fifo;
    t_baud;
    close_out;
  end
  // longest path is the slow baud codes, well inside this span
  initial begin
    #200000;
    n_fail++;
    close_out;
  end
endmodule
`default_nettype wire

//--- uart_err_pkg.sv
package uart_err_pkg;
  // register map (rx buffer address is a local choice)
  localparam logic [15:0] ERR_STATUS_ADDR = 16'hFF71;
  localparam logic [15:0] BAUD_CTRL_ADDR = 16'hFF73;
  localparam logic [15:0] RX_BUFFER_ADDR = 16'hFF74;
  localparam logic [7:0] ERR_STATUS_RESET = 8'h00;
  localparam logic [3:0] BAUD_SEL_RESET = 4'h0;
  localparam logic [7:0] RX_BUFFER_RESET = 8'h00;
  // field positions
  localparam int PE_BIT = 2;
  localparam int FE_BIT = 1;
  localparam int OVE_BIT = 0;
  localparam int BAUD_SEL_LSB = 4;
  // source select codes
  localparam logic [3:0] SEL_MAX_INTERNAL = 4'h7;
  localparam logic [3:0] SEL_EXTERNAL = 4'h8;
  // timing counts
  localparam logic [2:0] HALF_BIT_TICKS = 3'h3;
  localparam logic [2:0] FULL_BIT_TICKS = 3'h7;
  localparam logic [2:0] LAST_BIT_7 = 3'h6;
  localparam logic [2:0] LAST_BIT_8 = 3'h7;
  // buffering
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 11;
  typedef enum logic [1:0] {
    PAR_NONE,
    PAR_ZERO,
    PAR_ODD,
    PAR_EVEN
  } parity_e;
endpackage

//--- uart_line_partner.sv
`timescale 1ns/10ps
`default_nettype none
module uart_line_partner #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clock,
  output logic rxd
);
  initial rxd = 1'b1;
  task automatic put(input logic v);
    @(negedge clock);
    rxd = v;
    repeat (BIT_CLKS - 1) @(negedge clock);
  endtask
  // lsb first; line returns to its pulled-up idle after the stop bit
  task automatic send(input logic [7:0] b, input int nb, input logic hp, p, st);
    put(1'b0);
    for (int i = 0; i < nb; i++) put(b[i]);
    if (hp) put(p);
    put(st);
    put(1'b1);
    put(1'b1);
  endtask
endmodule
`default_nettype wire
